//--- design/pllcc_top.sv
`timescale 1ns/100ps
// Operation
// - locked system clock equals N times reference
// - phase detector sees reference and divider only
// - two pump outputs, idle at zero error
// - two-bit field selects pump current
// - programmable downcounter divides oscillator by N
// - software picks system clock source
// - loop source refused unless locked, glitch-free
// - lock after consecutive small-error reference cycles
// - lock criterion from control zero field
// - lock output high, usable as interrupt
// - reset: loop disabled, crystal drives clock
// - timer source also blocked until lock
// - factor loads on high write, minimum two
// - criteria codes: 8/16 cycles, 20/400 ns
// - source codes 0,1,2; code 3 keeps
// - lock gained/lost flags held until read
module pllcc_top #(
    parameter int DIV_WIDTH = pllcc_pkg::DIV_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic crystal_reference,
    input wire logic voltage_oscillator,
    input wire logic [7:0] wdata,
    input wire logic div_low_wr,
    input wire logic div_high_wr,
    input wire logic loop_control_zero_wr,
    input wire logic loop_control_one_wr,
    input wire logic loop_control_one_rd,
    input wire logic timer_loop_req,
    output logic phase_detector_up,
    output logic phase_detector_down,
    output logic [1:0] pump_current,
    output logic loop_enable,
    output logic divider_out,
    output logic lock_status,
    output logic lock_gained_flag,
    output logic lock_lost_flag,
    output logic [1:0] clock_source_select,
    output logic clk_en_crystal,
    output logic clk_en_loop,
    output logic clk_en_rtc,
    output logic timer_src_loop
);
    logic [7:0] div_low_r;
    logic [1:0] pump_r;
    logic [1:0] lock_criteria_select_r;
    logic [1:0] src_r;
    logic [1:0] src_nxt;
    logic enable_r;
    logic up_r;
    logic dn_r;
    logic ref_d_r;
    logic div_d_r;
    logic [7:0] err_r;
    logic [4:0] run_r;
    logic [4:0] run_nxt;
    logic locked_r;
    logic lock_d_r;
    logic gained_r;
    logic lost_r;
    logic [2:0] en_r;
    logic [2:0] en_nxt;
    logic timer_r;

    wire div_sig;
    wire [DIV_WIDTH-1:0] factor = DIV_WIDTH'({wdata, div_low_r});
    // factor and analog settings frozen while the loop runs
    wire div_load = div_high_wr & ~enable_r;
    wire ctl0_cfg_wr = loop_control_zero_wr & ~enable_r;
    wire [1:0] src_req = wdata[pllcc_pkg::SRC_LSB +: 2];

    pllcc_divider #(.WIDTH(DIV_WIDTH)) u_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .osc_in(voltage_oscillator),
        .load(div_load),
        .factor(factor),
        .div_out(div_sig)
    );

    // falling edges of the two detector inputs
    wire ref_fall = ref_d_r & ~crystal_reference;
    wire div_fall = div_d_r & ~div_sig;
    wire up_set = up_r | ref_fall;
    wire dn_set = dn_r | div_fall;
    // both pending means the edges met: reset both, so zero error
    // keeps the pump quiet
    wire pfd_clr = (up_set & dn_set) | ~enable_r;
    wire [7:0] err_inc = (up_r | dn_r) && err_r != 8'hFF ?
                         err_r + 8'h01 : err_r;

    function automatic int crit_cycles(input logic [1:0] sel);
        crit_cycles = sel[1] ? pllcc_pkg::LOOSE_CYC : pllcc_pkg::TIGHT_CYC;
    endfunction
    function automatic int crit_run(input logic [1:0] sel);
        crit_run = sel[0] ? pllcc_pkg::LOCK_RUN_LONG :
                            pllcc_pkg::LOCK_RUN_SHORT;
    endfunction

    wire err_ok = 32'(err_inc) < crit_cycles(lock_criteria_select_r);
    wire run_done = 32'(run_r) >= crit_run(lock_criteria_select_r);
    // a small error on each reference cycle extends the run
    assign run_nxt = !enable_r ? 5'h00 :
                     !ref_fall ? run_r :
                     !err_ok ? 5'h00 :
                     run_done ? run_r : run_r + 5'h01;
    wire locked_nxt = enable_r && (ref_fall ? (err_ok && 32'(run_nxt) >=
                      crit_run(lock_criteria_select_r)) : locked_r);

    // loop code refused while out of lock; code 3 keeps the last one
    assign src_nxt = (loop_control_zero_wr && src_req != pllcc_pkg::SRC_KEEP
                      && (src_req != pllcc_pkg::SRC_LOOP || locked_r)) ?
                     src_req :
                     (src_r == pllcc_pkg::SRC_LOOP && !locked_r) ?
                     pllcc_pkg::SRC_CRYSTAL_REFERENCE : src_r;
    wire [2:0] want = (3'h1 << src_r);
    // break before make: one dead cycle with no source enabled
    assign en_nxt = (en_r == want) ? en_r :
                    (en_r != 3'h0) ? 3'h0 : want;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div_low_r <= pllcc_pkg::DIV_LOW_RESET;
            pump_r <= pllcc_pkg::PUMP_RESET;
            lock_criteria_select_r <= pllcc_pkg::CRIT_RESET;
            enable_r <= 1'b0;
            src_r <= pllcc_pkg::SRC_CRYSTAL_REFERENCE;
            en_r <= 3'h1;
        end else begin
            if (div_low_wr && !enable_r) div_low_r <= wdata;
            if (ctl0_cfg_wr) begin
                pump_r <= wdata[pllcc_pkg::PUMP_LSB +: 2];
                lock_criteria_select_r <= wdata[pllcc_pkg::CRIT_LSB +: 2];
            end
            if (loop_control_one_wr) enable_r <= wdata[0];
            src_r <= src_nxt;
            en_r <= en_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ref_d_r <= 1'b0;
            div_d_r <= 1'b0;
            up_r <= 1'b0;
            dn_r <= 1'b0;
            err_r <= 8'h00;
            run_r <= 5'h00;
            locked_r <= 1'b0;
        end else begin
            ref_d_r <= crystal_reference;
            div_d_r <= div_sig;
            up_r <= up_set & ~pfd_clr;
            dn_r <= dn_set & ~pfd_clr;
            err_r <= ref_fall ? 8'h00 : err_inc;
            run_r <= run_nxt;
            locked_r <= locked_nxt;
        end
    end

    // event flags: a new edge wins over the read that clears
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lock_d_r <= 1'b0;
            gained_r <= 1'b0;
            lost_r <= 1'b0;
            timer_r <= 1'b0;
        end else begin
            lock_d_r <= locked_r;
            gained_r <= (locked_r & ~lock_d_r) |
                        (gained_r & ~loop_control_one_rd);
            lost_r <= (~locked_r & lock_d_r) |
                      (lost_r & ~loop_control_one_rd);
            timer_r <= timer_loop_req & locked_nxt;
        end
    end

    assign phase_detector_up = up_r;
    assign phase_detector_down = dn_r;
    assign pump_current = pump_r;
    assign loop_enable = enable_r;
    assign divider_out = div_sig;
    assign lock_status = locked_r;
    assign lock_gained_flag = gained_r;
    assign lock_lost_flag = lost_r;
    assign clock_source_select = src_r;
    assign clk_en_crystal = en_r[0];
    assign clk_en_loop = en_r[1];
    assign clk_en_rtc = en_r[2];
    assign timer_src_loop = timer_r;

    a_pump_exclusive: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !(up_r && dn_r))
        else $error("both pump outputs active");
    a_mux_onehot: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $onehot0(en_r))
        else $error("two clock sources enabled");
    a_loop_needs_lock: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $rose(en_r[1]) |-> $past(locked_r, 2))
        else $error("loop source enabled without lock");
    a_dead_cycle: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        en_r != 3'h0 && $changed(en_r) |-> $past(en_r) == 3'h0)
        else $error("source switch without dead cycle");
    a_reset_state: assert property (@(posedge sys_clk)
        !reset_n |=> en_r == 3'h1 && !enable_r && src_r == 2'h0)
        else $error("reset state wrong");
    a_keep_code: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        loop_control_zero_wr && src_req == 2'h3 && locked_r
        |=> src_r == $past(src_r))
        else $error("reserved source code changed selection");
    a_lock_run: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $rose(locked_r) |-> $past(ref_fall)
        && 32'($past(run_nxt)) >= crit_run($past(lock_criteria_select_r)))
        else $error("lock declared before run complete");
    a_lock_off: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !enable_r |=> !locked_r)
        else $error("lock while loop disabled");
    a_gain_flag: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $rose(locked_r) |=> gained_r)
        else $error("lock gained flag missed");
    a_lost_flag: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $fell(locked_r) |=> lost_r [*2])
        else $error("lock lost flag missed");
    a_timer_lock: assert property (@(posedge sys_clk)
        disable iff (!reset_n) timer_r |-> locked_r)
        else $error("timer on loop without lock");
    a_pump_field: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        ctl0_cfg_wr |=> pump_current == $past(wdata[7:6]))
        else $error("pump current field not applied");

    c_lock: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(locked_r));
    c_to_loop: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(en_r[1]));
    c_unlock: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(locked_r) && src_r == 2'h1);
    c_timer: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(timer_r));
endmodule

//--- design/pllcc_pkg.sv
package pllcc_pkg;
    localparam int CLK_NS = 100;
    localparam int TIGHT_NS = 20;
    localparam int LOOSE_NS = 400;
    // longest error times round down, never below one cycle
    localparam int TIGHT_CYC = (TIGHT_NS / CLK_NS) < 1 ? 1 : TIGHT_NS / CLK_NS;
    localparam int LOOSE_CYC = (LOOSE_NS / CLK_NS) < 1 ? 1 : LOOSE_NS / CLK_NS;
    localparam int LOCK_RUN_SHORT = 8;
    localparam int LOCK_RUN_LONG = 16;
    localparam int DIV_W = 11;
    localparam logic [10:0] DIV_MIN = 11'h002;
    localparam logic [10:0] DIV_RESET = 11'h002;
    localparam logic [7:0] DIV_LOW_RESET = 8'h02;
    localparam int PUMP_LSB = 6;
    localparam int CRIT_LSB = 2;
    localparam int SRC_LSB = 0;
    localparam logic [1:0] SRC_CRYSTAL_REFERENCE = 2'h0;
    localparam logic [1:0] SRC_LOOP = 2'h1;
    localparam logic [1:0] SRC_RTC = 2'h2;
    localparam logic [1:0] SRC_KEEP = 2'h3;
    localparam logic [1:0] PUMP_RESET = 2'h0;
    localparam logic [1:0] CRIT_RESET = 2'h0;
endpackage

//--- design/pllcc_divider.sv
`timescale 1ns/100ps
module pllcc_divider #(
    parameter int WIDTH = pllcc_pkg::DIV_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic osc_in,
    input wire logic load,
    input wire logic [WIDTH-1:0] factor,
    output logic div_out
);
    logic osc_d_r;
    logic [WIDTH-1:0] n_r;
    logic [WIDTH-1:0] n_nxt;
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic out_r;
    wire osc_rise = osc_in & ~osc_d_r;
    wire wrap = (cnt_r == '0);

    // factors below the minimum are replaced, not rejected
    assign n_nxt = load ? ((factor < WIDTH'(pllcc_pkg::DIV_MIN)) ?
                           WIDTH'(pllcc_pkg::DIV_MIN) : factor) : n_r;
    // downcounter: one wrap every n oscillator rising edges
    assign cnt_nxt = load ? '0 :
                     !osc_rise ? cnt_r :
                     wrap ? n_r - WIDTH'(1) : cnt_r - WIDTH'(1);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // track the pin in reset so release shows no false rise
            osc_d_r <= osc_in;
            n_r <= WIDTH'(pllcc_pkg::DIV_RESET);
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            osc_d_r <= osc_in;
            n_r <= n_nxt;
            cnt_r <= cnt_nxt;
            out_r <= (cnt_nxt >= (n_r >> 1)) && !load;
        end
    end
    assign div_out = out_r;

    a_div_floor: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        n_r >= WIDTH'(pllcc_pkg::DIV_MIN))
        else $error("divide factor below minimum");
    a_div_load: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        load && factor >= WIDTH'(pllcc_pkg::DIV_MIN) |=> n_r == $past(factor))
        else $error("divide factor not taken on load");
endmodule

//--- testbench/pllcc_analog_model.sv
`timescale 1ns/100ps
module pllcc_analog_model (
    input wire logic sys_clk,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic detune,
    output logic crystal_reference,
    output logic voltage_oscillator
);
    int ref_cnt = 0;
    int osc_cnt = 0;
    int half;
    logic osc_lvl = 1'b0;
    // crystal runs free at 1.6 us, slow next to the sampling clock
    assign crystal_reference = (ref_cnt < 8);
    assign voltage_oscillator = osc_lvl;
    // up means the divider is late, so speed up; one-cycle steps
    // keep the model short at the cost of some jitter
    assign half = detune ? 7 : (pump_up ? 3 : (pump_down ? 5 : 4));
    always @(posedge sys_clk) begin
        ref_cnt <= (ref_cnt + 1) % 16;
        osc_cnt <= osc_cnt + 1;
        if (osc_cnt >= half - 1) begin
            osc_cnt <= 0;
            osc_lvl <= ~osc_lvl;
        end
    end
endmodule

//--- testbench/tb_pll_clock_control_logic.sv
`timescale 1ns/100ps
module tb_pll_clock_control_logic;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [4:0] wr_s = 5'h00;
    logic timer_req = 1'b0;
    logic detune = 1'b0;
    logic xr, vo, up, dn, en, dv, lk, lg, ll, ec, el, er, ts;
    logic [1:0] pc, cs;
    int n_fail = 0;
    int comparisons = 0;
    always #50 sys_clk = ~sys_clk;
    pllcc_analog_model model (.sys_clk(sys_clk), .pump_up(up),
        .pump_down(dn), .detune(detune), .crystal_reference(xr),
        .voltage_oscillator(vo));
    pllcc_top dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .crystal_reference(xr), .voltage_oscillator(vo), .wdata(wdata),
        .div_low_wr(wr_s[0]), .div_high_wr(wr_s[1]),
        .loop_control_zero_wr(wr_s[2]), .loop_control_one_wr(wr_s[3]),
        .loop_control_one_rd(wr_s[4]), .timer_loop_req(timer_req),
        .phase_detector_up(up), .phase_detector_down(dn),
        .pump_current(pc), .loop_enable(en), .divider_out(dv),
        .lock_status(lk), .lock_gained_flag(lg), .lock_lost_flag(ll),
        .clock_source_select(cs), .clk_en_crystal(ec),
        .clk_en_loop(el), .clk_en_rtc(er), .timer_src_loop(ts));
    task automatic c1(input string s, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic c2(input string s, input logic [1:0] e,
        input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // k: 0 low, 1 high, 2 control zero, 3 control one, 4 read
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge sys_clk);
        wdata <= d;
        wr_s <= 5'h01 << k;
        @(posedge sys_clk);
        wr_s <= 5'h00;
        @(negedge sys_clk);
    endtask
    task automatic final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // switching stays clean on every cycle
    always @(negedge sys_clk) begin
        if (reset_n) begin
            c1("one_enable", 1'b1, $onehot0({ec, el, er}));
            c1("up_and_down", 1'b0, up & dn);
        end
    end
    task automatic t_reset;
        c1("loop_enable", 1'b0, en);
        c1("clk_en_crystal", 1'b1, ec);
        c2("source", 2'h0, cs);
        c1("lock", 1'b0, lk);
    endtask
    task automatic t_select;
        @(posedge sys_clk) timer_req <= 1'b1;
        wr(2, 8'h01);
        cyc(2);
        c2("source", 2'h0, cs);
        c1("clk_en_loop", 1'b0, el);
        c1("timer_src_loop", 1'b0, ts);
        wr(2, 8'h02);
        c2("source", 2'h2, cs);
        cyc(2);
        c1("clk_en_rtc", 1'b1, er);
        wr(2, 8'h03);
        c2("source", 2'h2, cs);
        wr(2, 8'h00);
        cyc(2);
        c1("clk_en_crystal", 1'b1, ec);
        for (int k = 0; k < 4; k++) begin
            wr(2, {k[1:0], 6'h08});
            c2("pump", k[1:0], pc);
        end
    endtask
    task automatic t_lock;
        int n;
        wr(0, 8'h00);
        wr(1, 8'h00);
        wr(0, 8'h03);
        wr(3, 8'h01);
        c1("loop_enable", 1'b1, en);
        for (n = 0; n < 3000 && lk !== 1'b1; n++) cyc(1);
        c1("lock", 1'b1, lk);
        c1("lock_not_early", 1'b1, n >= 112);
        cyc(1);
        c1("gained", 1'b1, lg);
    endtask
    // eight divider periods: osc rises must be exactly 8 * N
    task automatic t_ratio;
        int t, r, d;
        logic pv, pd;
        t = 0;
        r = 0;
        d = 0;
        pv = vo;
        pd = dv;
        while (d < 9 && t < 600) begin
            cyc(1);
            if (dv === 1'b1 && pd === 1'b0) d++;
            if (d > 0 && d < 9) begin
                t++;
                if (vo === 1'b1 && pv === 1'b0) r++;
            end
            pd = dv;
            pv = vo;
        end
        c1("osc_per_div", 1'b1, r == 16);
        c1("ref_ratio", 1'b1, t > 120 && t < 136);
    endtask
    task automatic t_use;
        wr(2, 8'h01);
        c2("pump_kept", 2'h3, pc);
        c2("source", 2'h1, cs);
        cyc(2);
        c1("clk_en_crystal", 1'b0, ec);
        c1("clk_en_loop", 1'b1, el);
        c1("timer_src_loop", 1'b1, ts);
        wr(4, 8'h00);
        c1("gained", 1'b0, lg);
    endtask
    task automatic t_lose;
        int n;
        @(posedge sys_clk) detune <= 1'b1;
        for (n = 0; n < 500 && lk !== 1'b0; n++) cyc(1);
        c1("lock", 1'b0, lk);
        cyc(1);
        c1("lost", 1'b1, ll);
        cyc(3);
        c2("source", 2'h0, cs);
        c1("clk_en_crystal", 1'b1, ec);
        c1("timer_src_loop", 1'b0, ts);
        wr(3, 8'h00);
        c1("loop_enable", 1'b0, en);
    endtask
    // long criterion: sixteen good reference cycles before lock
    task automatic t_relock;
        int n;
        @(posedge sys_clk) detune <= 1'b0;
        wr(2, 8'h0C);
        c2("pump", 2'h0, pc);
        wr(3, 8'h01);
        for (n = 0; n < 3000 && lk !== 1'b1; n++) cyc(1);
        c1("relock", 1'b1, lk);
        c1("long_run", 1'b1, n >= (pllcc_pkg::LOCK_RUN_LONG - 1) * 16);
        cyc(1);
        c1("gained_again", 1'b1, lg);
    endtask
    initial begin
        repeat (10000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(1);
        t_reset();
        t_select();
        t_lock();
        t_ratio();
        t_use();
        t_lose();
        t_relock();
        final_report();
    end
endmodule
